// File: verilog/acc_top.sv
// Purpose: Two-channel analog comparator control and output logic
// Assumes: Control bits are plain ports; analog results arrive asynchronously
// Notes:   Timer source clock and results pass a two-flop synchroniser
`timescale 1ns/10ps
// Contract
// - Comparator works only while enabled; disabled means analog core off.
// - Result readable in channel status bit and in shared mirror register.
// - Internal result latched once each instruction cycle.
// - External outputs always skip the cycle latch; sync mode uses the timer-edge latch instead.
// - Polarity 0 passes vp greater than vn as 1; polarity 1 inverts.
// - Hysteresis enable adds separation voltage; clear removes it.
// - Result is a gate source for the gate timer.
// - Sync set latches output on timer source clock falling edge.
// - Rise and fall detectors set flag when matching enable is set.
// - Flag cleared only by software; simultaneous edge leaves it set.
// - Toggling polarity or enable while off still makes an edge.
// - Positive select routes pin, DAC, fixed reference or ground.
// - Enable 0 disconnects all inputs regardless of selects.
// - Negative select routes pins, fixed reference or analog ground.
// - Analog-configured pins read 0 in port reads.
// - Active output with shutdown source enable suspends waveform generator.
// - Positive codes 000 pin, 101 DAC, 110 reference, 111 ground.
// - Negative codes 000-011 pins, 110 reference, 111 ground, others open.
// - Mirror register bit1 comparator 2, bit0 comparator 1, rest zero.
// - Sync clear passes output to timer and pin unlatched.
module acc_top #(
  parameter int unsigned ICYC_DIV = 4,   // System clocks per instruction cycle
  parameter int unsigned PORT_W   = 8    // Port width for read masking
) (
  input  wire logic              clk_i,             // 25 MHz clock
  input  wire logic              srst_i,            // Sync reset, high
  input  wire logic [1:0]        cmp_enable_i,      // Per-channel enable
  input  wire logic [1:0]        cmp_invert_i,      // Per-channel polarity
  input  wire logic [1:0]        cmp_hysteresis_en_i, // Hysteresis enable
  input  wire logic [1:0]        cmp_sync_en_i,     // Sync to gate timer
  input  wire logic [1:0]        rise_edge_irq_en_i, // Rise edge enable
  input  wire logic [1:0]        fall_edge_irq_en_i, // Fall edge enable
  input  wire logic [5:0]        pos_channel_sel_i, // {c2,c1} positive selects
  input  wire logic [5:0]        neg_channel_sel_i, // {c2,c1} negative selects
  input  wire logic [1:0]        cmp_raw_i,         // Async analog results
  input  wire logic              gate_timer_clk_i,  // Gate timer source clock
  input  wire logic [1:0]        flag_clr_i,        // Software flag clear pulse
  input  wire logic [1:0]        shutdown_source_en_i, // Shutdown source enables
  input  wire logic [PORT_W-1:0] port_pins_i,       // Port pin levels
  input  wire logic [PORT_W-1:0] analog_select_i,   // Analog pin selects
  output logic      [7:0]        pos_conn_o,        // {c2,c1} positive switches
  output logic      [11:0]       neg_conn_o,        // {c2,c1} negative switches
  output logic      [1:0]        analog_on_o,       // Analog core power
  output logic      [1:0]        hyst_on_o,         // Hysteresis switches
  output logic      [1:0]        cmp_result_o,      // Status result bits
  output logic      [7:0]        shared_result_reg_o, // Mirror register
  output logic      [1:0]        cmp_ext_o,         // To timer gate and pin
  output logic      [1:0]        cmp_irq_flag_o,    // Interrupt flags
  output logic                   waveform_shutdown_o, // Shutdown request
  output logic      [PORT_W-1:0] port_read_o        // Port read data
);
  logic [ICYC_DIV-1:0] div_reg;
  logic                icyc_tick;
  logic [1:0]          raw_s1_reg;
  logic [1:0]          raw_s2_reg;
  logic [2:0]          tclk_reg;
  logic                tmr_fall;
  logic [PORT_W-1:0]   pin_s1_reg;
  logic [PORT_W-1:0]   pin_s2_reg;
  logic [PORT_W-1:0]   port_reg;
  logic [1:0]          result_w;

  ////////////////////////////////////////////////////////////////////////////
  // Ring divider gives a one-cycle instruction tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      div_reg <= {{(ICYC_DIV-1){1'b0}}, 1'b1};
    end else begin
      div_reg <= {div_reg[ICYC_DIV-2:0], div_reg[ICYC_DIV-1]};
    end
  end
  assign icyc_tick = div_reg[ICYC_DIV-1];

  // Analog results and pins are outside the clock domain
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      raw_s1_reg <= 2'h0;
      raw_s2_reg <= 2'h0;
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end else begin
      raw_s1_reg <= cmp_raw_i;
      raw_s2_reg <= raw_s1_reg;
      pin_s1_reg <= port_pins_i;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Timer clock: two sync flops, third for falling edge detect
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tclk_reg <= 3'h0;
    end else begin
      tclk_reg <= {tclk_reg[1:0], gate_timer_clk_i};
    end
  end
  assign tmr_fall = tclk_reg[2] & ~tclk_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < acc_pkg::NUM_CMP; g++) begin : g_ch
      acc_channel u_ch (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .icyc_tick_i (icyc_tick),
        .tmr_fall_i  (tmr_fall),
        .enable_i    (cmp_enable_i[g]),
        .invert_i    (cmp_invert_i[g]),
        .hyst_i      (cmp_hysteresis_en_i[g]),
        .sync_i      (cmp_sync_en_i[g]),
        .rise_en_i   (rise_edge_irq_en_i[g]),
        .fall_en_i   (fall_edge_irq_en_i[g]),
        .pos_sel_i   (pos_channel_sel_i[g*3 +: 3]),
        .neg_sel_i   (neg_channel_sel_i[g*3 +: 3]),
        .raw_i       (raw_s2_reg[g]),
        .flag_clr_i  (flag_clr_i[g]),
        .pos_conn_o  (pos_conn_o[g*4 +: 4]),
        .neg_conn_o  (neg_conn_o[g*6 +: 6]),
        .analog_on_o (analog_on_o[g]),
        .hyst_on_o   (hyst_on_o[g]),
        .result_o    (result_w[g]),
        .ext_out_o   (cmp_ext_o[g]),
        .flag_o      (cmp_irq_flag_o[g])
      );
    end
  endgenerate

  assign cmp_result_o = result_w;

  always_comb begin
    shared_result_reg_o = 8'h00;
    shared_result_reg_o[acc_pkg::MIR_C1_BIT] = result_w[0];
    shared_result_reg_o[acc_pkg::MIR_C2_BIT] = result_w[1];
  end

  // Shutdown is combinational so suspension is immediate
  assign waveform_shutdown_o = |(cmp_ext_o & shutdown_source_en_i);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      port_reg <= '0;
    end else begin
      port_reg <= pin_s2_reg & ~analog_select_i;
    end
  end
  assign port_read_o = port_reg;

  mirror_bits_a: assert property (@(posedge clk_i) disable iff (srst_i)
    shared_result_reg_o == {6'h00, cmp_result_o}) else $error("mirror mismatch");
  shutdown_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (cmp_ext_o[0] & shutdown_source_en_i[0]) |-> waveform_shutdown_o)
    else $error("no shutdown");
  analog_zero_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ##1 (port_read_o & $past(analog_select_i)) == '0) else $error("analog pin read");
  tick_period_a: assert property (@(posedge clk_i) disable iff (srst_i)
    icyc_tick |=> ~icyc_tick [*3] ##1 icyc_tick) else $error("tick period");
endmodule

// File: shared/acc_pkg.sv
// Purpose: Shared constants for the analog comparator control block
// Assumes: Two comparator channels, instruction-cycle enable made by the acc_top ring divider from clk_i
// Notes:   Channel select codes and mirror bit positions
package acc_pkg;
  localparam int unsigned NUM_CMP = 2;
  localparam int unsigned SEL_W   = 3;
  localparam int unsigned OUT_W   = 8;
  // Positive channel codes
  localparam logic [2:0] PCH_PIN0 = 3'h0;
  localparam logic [2:0] PCH_DAC  = 3'h5;
  localparam logic [2:0] PCH_FVR  = 3'h6;
  localparam logic [2:0] PCH_GND  = 3'h7;
  // Negative channel codes
  localparam logic [2:0] NCH_PIN3 = 3'h3;
  localparam logic [2:0] NCH_FVR  = 3'h6;
  localparam logic [2:0] NCH_GND  = 3'h7;
  // Analog mux one-hot selects
  localparam int unsigned PSEL_W = 4;
  localparam int unsigned NSEL_W = 6;
  localparam int unsigned NSEL_FVR = 4;
  localparam int unsigned NSEL_GND = 5;
  localparam int unsigned PSEL_PIN = 0;
  localparam int unsigned PSEL_DAC = 1;
  localparam int unsigned PSEL_FVR = 2;
  localparam int unsigned PSEL_GND = 3;
  // Mirror register bits
  localparam int unsigned MIR_C1_BIT = 0;
  localparam int unsigned MIR_C2_BIT = 1;
endpackage

// File: verilog/acc_channel.sv
// Purpose: One comparator channel: select decode, polarity, latch, sync, edges
// Assumes: raw_i is already synchronised to clk_i
// Notes:   Tick inputs are one-cycle enables on clk_i
`timescale 1ns/10ps
module acc_channel (
  input  wire logic       clk_i,        // System clock
  input  wire logic       srst_i,       // Sync reset
  input  wire logic       icyc_tick_i,  // Instruction cycle enable
  input  wire logic       tmr_fall_i,   // Gate timer source falling edge
  input  wire logic       enable_i,     // Comparator enable
  input  wire logic       invert_i,     // Output polarity
  input  wire logic       hyst_i,       // Hysteresis enable
  input  wire logic       sync_i,       // Sync to timer clock
  input  wire logic       rise_en_i,    // Rise edge enable
  input  wire logic       fall_en_i,    // Fall edge enable
  input  wire logic [2:0] pos_sel_i,    // Positive channel select
  input  wire logic [2:0] neg_sel_i,    // Negative channel select
  input  wire logic       raw_i,        // Analog result, vp > vn
  input  wire logic       flag_clr_i,   // Software flag clear
  output logic      [3:0] pos_conn_o,   // Positive input switches
  output logic      [5:0] neg_conn_o,   // Negative input switches
  output logic            analog_on_o,  // Analog core powered
  output logic            hyst_on_o,    // Hysteresis switch
  output logic            result_o,     // Software visible result
  output logic            ext_out_o,    // To timer, pin, shutdown
  output logic            flag_o        // Interrupt flag
);
  logic pol_val;
  logic lat_reg;
  logic prev_reg;
  logic sync_reg;
  logic flag_reg;
  logic rise_evt;
  logic fall_evt;

  // Disabled core gives 0, so polarity still toggles output
  assign pol_val     = (enable_i & raw_i) ^ invert_i;
  assign analog_on_o = enable_i;
  assign hyst_on_o   = enable_i & hyst_i;

  always_comb begin
    pos_conn_o = '0;
    neg_conn_o = '0;
    if (enable_i) begin
      unique case (pos_sel_i)
        acc_pkg::PCH_PIN0: pos_conn_o[acc_pkg::PSEL_PIN] = 1'b1;
        acc_pkg::PCH_DAC:  pos_conn_o[acc_pkg::PSEL_DAC] = 1'b1;
        acc_pkg::PCH_FVR:  pos_conn_o[acc_pkg::PSEL_FVR] = 1'b1;
        acc_pkg::PCH_GND:  pos_conn_o[acc_pkg::PSEL_GND] = 1'b1;
        default:           pos_conn_o = '0;
      endcase
      if (neg_sel_i <= acc_pkg::NCH_PIN3) begin
        neg_conn_o[neg_sel_i[1:0]] = 1'b1;
      end else if (neg_sel_i == acc_pkg::NCH_FVR) begin
        neg_conn_o[acc_pkg::NSEL_FVR] = 1'b1;
      end else if (neg_sel_i == acc_pkg::NCH_GND) begin
        neg_conn_o[acc_pkg::NSEL_GND] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lat_reg  <= 1'b0;
      prev_reg <= 1'b0;
    end else if (icyc_tick_i) begin
      lat_reg  <= pol_val;
      prev_reg <= lat_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_reg <= 1'b0;
    end else if (tmr_fall_i) begin
      sync_reg <= pol_val;
    end
  end

  // Unsynchronised path bypasses the cycle latch
  assign ext_out_o = sync_i ? sync_reg : pol_val;
  assign result_o  = sync_i ? sync_reg : lat_reg;

  assign rise_evt = icyc_tick_i & (lat_reg & ~prev_reg) & rise_en_i;
  assign fall_evt = icyc_tick_i & (~lat_reg & prev_reg) & fall_en_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flag_reg <= 1'b0;
    end else if (rise_evt | fall_evt) begin
      flag_reg <= 1'b1;
    end else if (flag_clr_i) begin
      flag_reg <= 1'b0;
    end
  end
  assign flag_o = flag_reg;

  flag_set_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (rise_evt | fall_evt) |=> flag_reg) else $error("edge did not set flag");
  set_wins_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (flag_clr_i & rise_evt) |=> flag_reg) else $error("clear beat edge");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (flag_reg & ~flag_clr_i) |=> flag_reg) else $error("flag dropped");
  latch_tick_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ~icyc_tick_i |=> $stable(lat_reg)) else $error("latch moved off tick");
  inputs_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ~enable_i |-> (pos_conn_o == '0 && neg_conn_o == '0)) else $error("input on");
  async_path_a: assert property (@(posedge clk_i) disable iff (srst_i)
    ~sync_i |-> ext_out_o == ((enable_i & raw_i) ^ invert_i)) else $error("async bad");
  sync_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (sync_i & ~tmr_fall_i) |=> (~sync_i || $stable(ext_out_o))) else $error("sync moved");
  // A rise leaves prev high, so the same transition cannot fire again
  edge_once_a: assert property (@(posedge clk_i) disable iff (srst_i)
    rise_evt |=> prev_reg) else $error("edge flagged twice");
endmodule

// File: tb/acc_analog_model.sv
// Purpose: Far side of the comparators: analog levels and gate timer clock
// Assumes: Levels are 8-bit codes per channel, {c2,c1}
// Notes:   Timer clock rests low and only pulses on request
`timescale 1ns/10ps
module acc_analog_model #(
  parameter int RESP_NS = 170  // Slow comparator response, longer than one instruction cycle
) (
  input  wire logic [15:0] vp_i,      // Non-inverting levels
  input  wire logic [15:0] vn_i,      // Inverting levels
  input  wire logic        tmr_req_i, // Request one timer clock pulse
  output logic      [1:0]  raw_o,     // Comparator decisions
  output logic             tmr_clk_o  // Gate timer source clock
);
  initial raw_o = 2'h0;
  initial tmr_clk_o = 1'b0;
  always @(vp_i, vn_i) begin
    raw_o[0] <= #(RESP_NS) (vp_i[7:0] > vn_i[7:0]);
    raw_o[1] <= #(RESP_NS) (vp_i[15:8] > vn_i[15:8]);
  end
  // Pulse width off the bench period so edges land at unrelated phase
  always @(posedge tmr_req_i) begin
    tmr_clk_o = 1'b1;
    #130;
    tmr_clk_o = 1'b0;
  end
endmodule

// File: tb/test_acc_top.sv
// Purpose: Self-checking bench for the comparator control block
// Assumes: Four clocks per instruction cycle
// Notes:   Drivers queue expectations, a watcher compares them
`timescale 1ns/10ps
`define CHK(nm, e, s) begin cmp_count++; if ((e) !== (s)) begin miscompares++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module test_acc_top;
  typedef struct {string nm; int sel; logic [11:0] exp;} acc_note_t;
  localparam int SETTLE = 20;
  logic clk_i = 1'b0, srst_i = 1'b1, tmr_req = 1'b0, gclk;
  logic [1:0] en = 0, inv = 0, hys = 0, syn = 0, rise = 0, fall = 0, clr = 0, sd = 0, raw;
  logic [5:0] psel = 0, nsel = 0;
  logic [7:0] pins = 0, asel = 0, pc, shr, prd;
  logic [15:0] vp = 16'h8080, vn = 16'hc0c0;
  logic [11:0] nc;
  logic [1:0] aon, hon, res, ext, flg;
  logic wsd;
  int miscompares = 0, cmp_count = 0, cycles = 0, race_hits = 0;
  acc_note_t q[$];
  event look;
  always #20 clk_i = ~clk_i;
  acc_analog_model u_acc_analog_model (.vp_i(vp), .vn_i(vn), .tmr_req_i(tmr_req),
    .raw_o(raw), .tmr_clk_o(gclk));
  acc_top u_acc_top (.clk_i(clk_i), .srst_i(srst_i), .cmp_enable_i(en), .cmp_invert_i(inv),
    .cmp_hysteresis_en_i(hys), .cmp_sync_en_i(syn), .rise_edge_irq_en_i(rise),
    .fall_edge_irq_en_i(fall), .pos_channel_sel_i(psel), .neg_channel_sel_i(nsel),
    .cmp_raw_i(raw), .gate_timer_clk_i(gclk), .flag_clr_i(clr), .shutdown_source_en_i(sd),
    .port_pins_i(pins), .analog_select_i(asel), .pos_conn_o(pc), .neg_conn_o(nc),
    .analog_on_o(aon), .hyst_on_o(hon), .cmp_result_o(res), .shared_result_reg_o(shr),
    .cmp_ext_o(ext), .cmp_irq_flag_o(flg), .waveform_shutdown_o(wsd), .port_read_o(prd));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] obs(int s);
    case (s)
      0: return {4'h0, pc};
      1: return nc;
      2: return {10'h0, aon};
      3: return {10'h0, hon};
      4: return {10'h0, res};
      5: return {4'h0, shr};
      6: return {10'h0, ext};
      7: return {10'h0, flg};
      8: return {11'h0, wsd};
      9: return {4'h0, prd};
      default: return 12'(race_hits);
    endcase
  endfunction
  function automatic logic [3:0] pexp(int c, int e);
    if (e == 0) return 4'h0;
    case (c)
      0: return 4'h1;
      5: return 4'h2;
      6: return 4'h4;
      7: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction
  function automatic logic [5:0] nexp(int c, int e);
    if (e == 0 || c == 4 || c == 5) return 6'h00;
    return (c < 4) ? 6'(1 << c) : ((c == 6) ? 6'h10 : 6'h20);
  endfunction
  always @(look) begin
    acc_note_t n;
    while (q.size() > 0) begin
      n = q.pop_front();
      `CHK(n.nm, n.exp, obs(n.sel))
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic note(string nm, int s, logic [11:0] e);
    q.push_back('{nm, s, e});
    -> look;
    // Hold the driver until the watcher has looked, before inputs move
    wait (q.size() == 0);
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic set_v(logic [1:0] r);
    vn = {r[1] ? 8'h40 : 8'hc0, r[0] ? 8'h40 : 8'hc0};
    cyc(SETTLE);
  endtask
  task automatic clear_flags();
    clr = 2'h3;
    cyc(1);
    clr = 2'h0;
    cyc(1);
  endtask
  task automatic tpulse();
    tmr_req = 1'b1;
    cyc(1);
    tmr_req = 1'b0;
    cyc(10);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] r;
    void'($urandom(32'he11e));
    cyc(8);
    srst_i = 1'b0;
    for (int e = 0; e < 2; e++) begin
      for (int c = 0; c < 8; c++) begin
        en = e ? 2'h3 : 2'h0;
        hys = 2'($urandom);
        psel = {3'(7 - c), 3'(c)};
        nsel = psel;
        cyc(1);
        note("pos", 0, {4'h0, pexp(7 - c, e), pexp(c, e)});
        note("neg", 1, {nexp(7 - c, e), nexp(c, e)});
        note("aon", 2, {10'h0, en});
        note("hys", 3, {10'h0, en & hys});
      end
    end
    for (int k = 0; k < 4; k++) begin
      r = 2'($urandom);
      inv = 2'(k);
      sd = 2'($urandom);
      set_v(r);
      note("ext", 6, {10'h0, r ^ inv});
      note("res", 4, {10'h0, r ^ inv});
      note("mir", 5, {10'h0, r ^ inv});
      note("sd", 8, {11'h0, |((r ^ inv) & sd)});
    end
    inv = 2'h0;
    rise = 2'h3;
    set_v(2'h0);
    clear_flags();
    note("flg", 7, 12'h0);
    set_v(2'h3);
    note("flg", 7, 12'h3);
    clear_flags();
    cyc(8);
    note("flg", 7, 12'h0);
    set_v(2'h0);
    note("flg", 7, 12'h0);
    rise = 2'h0;
    fall = 2'h3;
    set_v(2'h3);
    note("flg", 7, 12'h0);
    set_v(2'h0);
    note("flg", 7, 12'h3);
    // Clear pulse on every instruction tick while a rise arrives: the
    // edge tick must leave the flag set, the later ticks clear it
    rise = 2'h3;
    fall = 2'h0;
    clear_flags();
    vn = 16'h4040;
    repeat (6) begin
      while (cycles % 4 != 3) cyc(1);
      clr = 2'h3;
      cyc(1);
      clr = 2'h0;
      race_hits += int'(flg == 2'h3);
    end
    note("race", 10, 12'h1);
    en = 2'h0;
    rise = 2'h3;
    fall = 2'h0;
    cyc(SETTLE);
    clear_flags();
    inv = 2'h3;
    cyc(SETTLE);
    note("flg", 7, 12'h3);
    inv = 2'h0;
    en = 2'h3;
    syn = 2'h3;
    set_v(2'h3);
    tpulse();
    note("res", 4, 12'h3);
    set_v(2'h0);
    note("res", 4, 12'h3);
    note("ext", 6, 12'h3);
    tpulse();
    note("ext", 6, 12'h0);
    syn = 2'h0;
    for (int k = 0; k < 4; k++) begin
      pins = 8'($urandom);
      asel = 8'($urandom);
      cyc(4);
      note("port", 9, {4'h0, pins & ~asel});
    end
    cyc(1);
    wrap_up();
  end
endmodule
